// ### rtl/bar_agent.sv
/*
 * Bus agent reset, power-good, machine-check, thermal alert, request
 * command and response status logic. Assumes all bus pins are resolved
 * outside from the output enables, and core-side inputs are on ref_clk.
 */
// Functional notes
// - any agent may drive machine check line
// - machine check assertion enabled or disabled globally
// - internal errors assert machine check with internal error
// - initiator asserts machine check on own transaction error
// - broadest option: assert on any transaction error
// - drive thermal alert at maximum safe temperature
// - external thermal alert engages thermal control circuit
// - thermal control stays active until line released
// - only bus owner drives request command lines
// - capture request command on address strobe edge
// - bus reset gives known state, invalidates without writeback
// - release all bus outputs within two clocks
// - latch configuration inputs at reset release
// - only response agent drives response status lines
// - response parity even-low rule, high when idle
// - soft init active at reset release starts self-test
`timescale 1ns/100ps
module bar_agent
	import bar_pkg::*;
#(
	parameter int CFG_W         = 8,
	parameter int RESET_MAX_CYC = RESET_MAX_DEF_CYC,
	parameter int MCE_PULSE     = MCE_PULSE_CYC
)(
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              sys_rst,
	// Register port
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	output logic                   irq,
	// Core side
	input  wire logic              core_internal_error,
	input  wire logic              txn_error,
	input  wire logic              txn_initiator,
	input  wire logic              bus_owner,
	input  wire logic              resp_agent,
	input  wire logic              temp_at_max,
	output logic                   thermal_control_circuit,
	output logic                   internal_error_n,
	output logic                   cache_invalidate,
	output logic                   bist_start,
	// Machine check line
	input  wire logic              machine_check_error_n_in,
	output logic                   machine_check_error_n_out,
	output logic                   machine_check_error_n_oe,
	// Thermal alert line
	input  wire logic              thermal_alert_n_in,
	output logic                   thermal_alert_n_out,
	output logic                   thermal_alert_n_oe,
	// Reset, power and configuration pins
	input  wire logic              bus_reset_n,
	input  wire logic              power_good_in,
	input  wire logic              soft_init_n,
	input  wire logic [CFG_W-1:0]  config_pins,
	// Request command lines and strobe
	input  wire logic              address_strobe0_n,
	input  wire logic [REQ_W-1:0]  request_cmd_n_in,
	output logic      [REQ_W-1:0]  request_cmd_n_out,
	output logic                   request_cmd_n_oe,
	// Response status and parity
	input  wire logic [RS_W-1:0]   response_status_n_in,
	output logic      [RS_W-1:0]   response_status_n_out,
	output logic                   response_status_n_oe,
	input  wire logic              response_parity_n_in,
	output logic                   response_parity_n_out,
	output logic                   response_parity_n_oe
);

	localparam int LO_W = 1 + RS_W + REQ_W + 4;
	localparam int HI_W = CFG_W + 2;
	localparam int MC_W = $clog2(MCE_PULSE + 1);
	localparam int RC_W = $clog2(RESET_MAX_CYC + 1);
	localparam logic [MC_W-1:0] MCE_LOAD = MC_W'(MCE_PULSE);
	localparam logic [RC_W-1:0] RST_LAST = RC_W'(RESET_MAX_CYC - 1);

	// Synchronised pins
	logic [LO_W-1:0]   lo_s;
	logic [HI_W-1:0]   hi_s;
	logic              mce_s, hot_s, init_n_s, stb_s, rsp_s;
	logic [REQ_W-1:0]  req_s;
	logic [RS_W-1:0]   rs_s;
	logic [CFG_W-1:0]  cfg_s;
	logic              pg_s, bus_rst_obs;

	bar_sync #(.W(LO_W), .INIT({LO_W{1'b1}})) u_sync_lo (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.d       ({response_parity_n_in, response_status_n_in,
		           request_cmd_n_in, address_strobe0_n, soft_init_n,
		           thermal_alert_n_in, machine_check_error_n_in}),
		.q       (lo_s)
	);

	bar_sync #(.W(HI_W), .INIT({HI_W{1'b0}})) u_sync_hi (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.d       ({config_pins, power_good_in, bus_reset_n}),
		.q       (hi_s)
	);

	assign {rsp_s, rs_s, req_s, stb_s, init_n_s, hot_s, mce_s} = lo_s;
	assign {cfg_s, pg_s} = hi_s[HI_W-1:1];
	assign bus_rst_obs = ~hi_s[0];

	// Reset sequencing
	bar_state_t state_reg;
	logic       rst_entry, rst_release;

	assign rst_entry   = (state_reg == ST_RUN) && bus_rst_obs;
	assign rst_release = (state_reg == ST_RESET) && !bus_rst_obs;

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			state_reg <= ST_RESET;
		else
			case (state_reg)
			ST_RUN:   state_reg <= bus_rst_obs ? ST_RESET : ST_RUN;
			ST_RESET: state_reg <= bus_rst_obs ? ST_RESET : ST_RUN;
			default:  state_reg <= ST_RESET;
			endcase
	end

	logic [CFG_W-1:0] cfg_reg;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cfg_reg          <= '0;
			bist_start       <= 1'b0;
			cache_invalidate <= 1'b0;
		end else begin
			if (rst_release)
				cfg_reg <= cfg_s;
			bist_start       <= rst_release && !init_n_s;
			cache_invalidate <= rst_entry;
		end
	end

	// Reset held too long while power is good
	logic [RC_W-1:0] rst_cnt_reg;
	logic            rst_long;

	assign rst_long = bus_rst_obs && pg_s && (rst_cnt_reg == RST_LAST);

	always_ff @(posedge ref_clk) begin
		if (sys_rst || !bus_rst_obs || !pg_s)
			rst_cnt_reg <= '0;
		else if (rst_cnt_reg != RST_LAST + 1'b1)
			rst_cnt_reg <= rst_cnt_reg + 1'b1;
	end

	// Software registers
	logic [CTRL_W-1:0] ctrl_reg;
	logic [REQ_W:0]    req_drv_reg;
	logic [RS_W:0]     rsp_drv_reg;

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			ctrl_reg <= CTRL_RST;
		else if (reg_wr && reg_addr == OFS_CTRL)
			ctrl_reg <= reg_wdata[CTRL_W-1:0];
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst || bus_rst_obs) begin
			req_drv_reg <= '0;
			rsp_drv_reg <= '0;
		end else if (reg_wr) begin
			if (reg_addr == OFS_REQ_DRIVE)
				req_drv_reg <= {reg_wdata[DRIVE_BIT], reg_wdata[REQ_W-1:0]};
			if (reg_addr == OFS_RSP_DRIVE)
				rsp_drv_reg <= {reg_wdata[DRIVE_BIT], reg_wdata[RS_W-1:0]};
		end
	end

	// Machine check drive
	logic            mce_fire;
	logic [MC_W-1:0] mce_cnt_reg, mce_cnt_next;

	assign mce_fire = ctrl_reg[CTRL_MCE_EN] && !bus_rst_obs &&
		((ctrl_reg[CTRL_MCE_INT] && core_internal_error) ||
		 (ctrl_reg[CTRL_MCE_INIT] && txn_error && txn_initiator) ||
		 (ctrl_reg[CTRL_MCE_ANY] && txn_error));

	always_comb begin
		mce_cnt_next = mce_cnt_reg;
		if (bus_rst_obs)
			mce_cnt_next = '0;
		else if (mce_fire)
			mce_cnt_next = MCE_LOAD;
		else if (mce_cnt_reg != '0)
			mce_cnt_next = mce_cnt_reg - 1'b1;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			mce_cnt_reg               <= '0;
			machine_check_error_n_oe  <= 1'b0;
			machine_check_error_n_out <= 1'b1;
			internal_error_n          <= 1'b1;
		end else begin
			mce_cnt_reg               <= mce_cnt_next;
			machine_check_error_n_oe  <= mce_cnt_next != '0;
			machine_check_error_n_out <= mce_cnt_next == '0;
			if (bus_rst_obs)
				internal_error_n <= 1'b1;
			else if (core_internal_error)
				internal_error_n <= 1'b0;
		end
	end

	// Thermal alert; own drive echoes back through the pin synchroniser
	logic [OWN_ECHO_CYC-1:0] hot_own_reg, mce_own_reg;
	logic                    ext_hot, ext_hot_d, temp_d, mce_d;

	assign ext_hot = !hot_s && !(|hot_own_reg);

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			thermal_alert_n_oe      <= 1'b0;
			thermal_alert_n_out     <= 1'b1;
			thermal_control_circuit <= 1'b0;
			hot_own_reg             <= '0;
			mce_own_reg             <= '0;
			ext_hot_d               <= 1'b0;
			temp_d                  <= 1'b0;
			mce_d                   <= 1'b1;
		end else begin
			thermal_alert_n_oe  <= temp_at_max && !bus_rst_obs;
			thermal_alert_n_out <= !(temp_at_max && !bus_rst_obs);
			thermal_control_circuit <= ctrl_reg[CTRL_TCC_EN] &&
				(temp_at_max || ext_hot);
			hot_own_reg <= {hot_own_reg[OWN_ECHO_CYC-2:0],
			                thermal_alert_n_oe};
			mce_own_reg <= {mce_own_reg[OWN_ECHO_CYC-2:0],
			                machine_check_error_n_oe};
			ext_hot_d   <= ext_hot;
			temp_d      <= temp_at_max;
			mce_d       <= mce_s;
		end
	end

	// Request command capture on the strobe falling edge
	logic             stb_d, stb_fall;
	logic [REQ_W-1:0] req_seen_reg;

	assign stb_fall = stb_d && !stb_s;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			stb_d        <= 1'b1;
			req_seen_reg <= '0;
		end else begin
			stb_d <= stb_s;
			if (stb_fall)
				req_seen_reg <= ~req_s;
		end
	end

	// Request and response drive
	logic [RS_W-1:0] rs_next;
	logic            rs_par_err;

	assign rs_next = rsp_drv_reg[RS_W] ? rsp_drv_reg[RS_W-1:0] : '0;
	assign rs_par_err = !response_status_n_oe && (~rs_s != '0) &&
		(rsp_s != ~^(~rs_s));

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			request_cmd_n_oe      <= 1'b0;
			request_cmd_n_out     <= '1;
			response_status_n_oe  <= 1'b0;
			response_status_n_out <= '1;
			response_parity_n_oe  <= 1'b0;
			response_parity_n_out <= 1'b1;
		end else begin
			request_cmd_n_oe <= req_drv_reg[REQ_W] && bus_owner &&
				!bus_rst_obs;
			request_cmd_n_out    <= ~req_drv_reg[REQ_W-1:0];
			response_status_n_oe <= rsp_drv_reg[RS_W] && resp_agent &&
				!bus_rst_obs;
			response_parity_n_oe <= rsp_drv_reg[RS_W] && resp_agent &&
				!bus_rst_obs;
			response_status_n_out <= ~rs_next;
			response_parity_n_out <= ~^rs_next;
		end
	end

	// Interrupts
	logic [EV_W-1:0] ev, irq_status, irq_enable;

	always_comb begin
		ev              = EV_RST;
		ev[EV_MCE_SEEN] = mce_d && !mce_s && !(|mce_own_reg);
		ev[EV_EXT_HOT]  = ext_hot && !ext_hot_d;
		ev[EV_INT_HOT]  = temp_at_max && !temp_d;
		ev[EV_REQ]      = stb_fall;
		ev[EV_RSP_PAR]  = rs_par_err;
		ev[EV_RST_REL]  = rst_release;
		ev[EV_RST_LONG] = rst_long;
	end

	bar_irq #(.W(EV_W)) u_irq (
		.ref_clk    (ref_clk),
		.sys_rst    (sys_rst),
		.event_set  (ev),
		.clear_wr   (reg_wr && reg_addr == OFS_IRQ_CLEAR),
		.enable_wr  (reg_wr && reg_addr == OFS_IRQ_ENABLE),
		.wdata      (reg_wdata[EV_W-1:0]),
		.status_reg (irq_status),
		.enable_reg (irq_enable),
		.irq        (irq)
	);

	// Read data stands only in the cycle after the read strobe
	logic [ST_W-1:0]   sts;
	logic [DATA_W-1:0] rd_val;

	always_comb begin
		sts               = '0;
		sts[STS_TCC]      = thermal_control_circuit;
		sts[STS_BUS_RST]  = bus_rst_obs;
		sts[STS_PWR_GOOD] = pg_s;
		sts[STS_MCE_DRV]  = machine_check_error_n_oe;
		sts[STS_HOT_DRV]  = thermal_alert_n_oe;
		sts[STS_INT_ERR]  = !internal_error_n;
		rd_val = '0;
		case (reg_addr)
		OFS_CTRL:       rd_val[CTRL_W-1:0] = ctrl_reg;
		OFS_STATUS:     rd_val[ST_W-1:0]   = sts;
		OFS_CONFIG:     rd_val[CFG_W-1:0]  = cfg_reg;
		OFS_REQ_SEEN:   rd_val[REQ_W-1:0]  = req_seen_reg;
		OFS_REQ_DRIVE:  rd_val = {{(DATA_W-DRIVE_BIT-1){1'b0}},
			req_drv_reg[REQ_W], {(DRIVE_BIT-REQ_W){1'b0}},
			req_drv_reg[REQ_W-1:0]};
		OFS_RSP_DRIVE:  rd_val = {{(DATA_W-DRIVE_BIT-1){1'b0}},
			rsp_drv_reg[RS_W], {(DRIVE_BIT-RS_W){1'b0}},
			rsp_drv_reg[RS_W-1:0]};
		OFS_IRQ_STATUS: rd_val[EV_W-1:0]   = irq_status;
		OFS_IRQ_ENABLE: rd_val[EV_W-1:0]   = irq_enable;
		default:        rd_val = '0;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			reg_rdata <= '0;
		else
			reg_rdata <= reg_rd ? rd_val : '0;
	end

	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	out_release_a: assert property (bus_rst_obs |-> ##[1:2]
		!(machine_check_error_n_oe || thermal_alert_n_oe ||
		  request_cmd_n_oe || response_status_n_oe))
		else $error("bus outputs still driven in reset");
	mce_gate_a: assert property ($rose(machine_check_error_n_oe) |->
		$past(ctrl_reg[CTRL_MCE_EN]))
		else $error("machine check driven while disabled");
	mce_hold_a: assert property (mce_fire |=>
		(!machine_check_error_n_out && machine_check_error_n_oe)[*4])
		else $error("machine check pulse too short");
	int_err_a: assert property (core_internal_error && !bus_rst_obs |=>
		!internal_error_n)
		else $error("internal error output not asserted");
	hot_drive_a: assert property (temp_at_max && !bus_rst_obs |=>
		thermal_alert_n_oe && !thermal_alert_n_out)
		else $error("thermal alert not driven");
	tcc_hold_a: assert property (ext_hot && ctrl_reg[CTRL_TCC_EN] |=>
		thermal_control_circuit)
		else $error("thermal control released early");
	req_owner_a: assert property (request_cmd_n_oe |->
		$past(bus_owner))
		else $error("request lines driven without ownership");
	rs_agent_a: assert property (response_status_n_oe |->
		$past(resp_agent) && response_parity_n_oe)
		else $error("response driven by non response agent");
	rsp_parity_a: assert property (response_parity_n_out ==
		~^(~response_status_n_out))
		else $error("response parity wrong");
	req_capture_a: assert property (stb_fall |=>
		req_seen_reg == ~$past(req_s))
		else $error("request command not captured");
	cfg_latch_a: assert property (rst_release |=>
		cfg_reg == $past(cfg_s) && state_reg == ST_RUN)
		else $error("configuration not latched");
	bist_a: assert property (rst_release && !init_n_s |=> bist_start)
		else $error("self-test not started");
	inval_a: assert property ($rose(bus_rst_obs) && state_reg == ST_RUN
		|=> cache_invalidate ##1 !cache_invalidate)
		else $error("cache invalidate pulse wrong");

endmodule : bar_agent

// ### rtl/bar_pkg.sv
/*
 * Shared constants and types of the bus agent reset and error block:
 * register offsets, control and event bit positions, reset values and
 * cycle counts. Assumes a 125 MHz ref_clk and 32-bit register data.
 */
package bar_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int REQ_W  = 5;
	localparam int RS_W   = 3;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL       = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_CONFIG     = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_REQ_SEEN   = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_REQ_DRIVE  = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_RSP_DRIVE  = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h1c;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR  = 8'h20;

	// Control register fields
	localparam int CTRL_W        = 5;
	localparam int CTRL_MCE_EN   = 0;
	localparam int CTRL_MCE_INT  = 1;
	localparam int CTRL_MCE_INIT = 2;
	localparam int CTRL_MCE_ANY  = 3;
	localparam int CTRL_TCC_EN   = 4;
	localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;

	// Drive enable bit in the request and response drive registers
	localparam int DRIVE_BIT = 8;

	// Status register fields
	localparam int ST_W          = 6;
	localparam int STS_TCC       = 0;
	localparam int STS_BUS_RST   = 1;
	localparam int STS_PWR_GOOD  = 2;
	localparam int STS_MCE_DRV   = 3;
	localparam int STS_HOT_DRV   = 4;
	localparam int STS_INT_ERR   = 5;

	// Event bits, shared by interrupt status, enable and clear
	localparam int EV_W        = 7;
	localparam int EV_MCE_SEEN = 0;
	localparam int EV_EXT_HOT  = 1;
	localparam int EV_INT_HOT  = 2;
	localparam int EV_REQ      = 3;
	localparam int EV_RSP_PAR  = 4;
	localparam int EV_RST_REL  = 5;
	localparam int EV_RST_LONG = 6;
	localparam logic [EV_W-1:0] EV_RST = 7'h00;

	// Timing
	localparam int CLK_PERIOD_NS     = 8;
	localparam int RESET_MAX_MS      = 10;
	localparam int RESET_MAX_DEF_CYC = RESET_MAX_MS * 1000000 / CLK_PERIOD_NS;
	localparam int RELEASE_MAX_CLK   = 2;
	localparam int MCE_PULSE_CYC     = 4;
	localparam int OWN_ECHO_CYC      = 3;

	typedef enum logic [1:0] {
		ST_RUN   = 2'b01,
		ST_RESET = 2'b10
	} bar_state_t;

endpackage : bar_pkg

// ### rtl/bar_sync.sv
/*
 * Two flip-flop synchroniser for a vector of unrelated levels.
 * Assumes each bit is independent; no bus coherency is offered.
 */
`timescale 1ns/100ps
module bar_sync
	import bar_pkg::*;
#(
	parameter int         W    = 1,
	parameter logic [W-1:0] INIT = '0
)(
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         sys_rst,
	// Levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_reg;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			meta_reg <= INIT;
			q        <= INIT;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end

endmodule : bar_sync

// ### rtl/bar_irq.sv
/*
 * Sticky event status with enable mask and write-one-to-clear.
 * Assumes events are one-cycle pulses on ref_clk; set wins over clear.
 */
`timescale 1ns/100ps
module bar_irq
	import bar_pkg::*;
#(
	parameter int W = EV_W
)(
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         sys_rst,
	// Events and software access
	input  wire logic [W-1:0] event_set,
	input  wire logic         clear_wr,
	input  wire logic         enable_wr,
	input  wire logic [W-1:0] wdata,
	// State
	output logic      [W-1:0] status_reg,
	output logic      [W-1:0] enable_reg,
	output logic              irq
);

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			status_reg <= '0;
		else if (clear_wr)
			status_reg <= (status_reg & ~wdata) | event_set;
		else
			status_reg <= status_reg | event_set;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			enable_reg <= '0;
		else if (enable_wr)
			enable_reg <= wdata;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			irq <= 1'b0;
		else
			irq <= |(status_reg & enable_reg);
	end

endmodule : bar_irq

// ### bench/bar_far.sv
/*
 * Far-side agent model: reset and power pins, request strobe, response
 * status, thermal and machine check pulls. Assumes the bench resolves
 * each shared line from all enables, released lines pulled high.
 */
`timescale 1ns/100ps
module bar_far;
	logic       bus_reset_n   = 1'b1;
	logic       power_good_in = 1'b1;
	logic       soft_init_n   = 1'b1;
	logic [7:0] config_pins   = 8'h3c;
	logic       strobe_n      = 1'b1;
	logic       req_oe        = 1'b0;
	logic [4:0] req_n         = 5'h1f;
	logic       rs_oe         = 1'b0;
	logic [2:0] rs_n          = 3'h7;
	logic       rsp_n         = 1'b1;
	logic       hot_n         = 1'b1;
	logic       mce_n         = 1'b1;

	// Strobe moves only inside the frame, 80 ns period
	// Pins start moving off the ref_clk edge so no edge races them
	task automatic send_req(input logic [4:0] cmd);
		#2;
		req_oe = 1'b1;
		req_n = ~cmd;
		#40 strobe_n = 1'b0;
		#40 strobe_n = 1'b1;
		#40 req_oe = 1'b0;
	endtask : send_req

	task automatic send_rsp(input logic [2:0] st, input logic good);
		#2;
		rs_oe = 1'b1;
		rs_n = ~st;
		rsp_n = good ? ~^st : ^st;
		#80 rs_oe = 1'b0;
	endtask : send_rsp

	task automatic pull_mce();
		#2;
		mce_n = 1'b0;
		#80 mce_n = 1'b1;
	endtask : pull_mce

	// Held past the long-reset limit only when the bench asks for it
	task automatic bus_reset(input int ns, input logic [7:0] cfg,
		input logic soft_n);
		#2;
		config_pins = cfg;
		soft_init_n = soft_n;
		bus_reset_n = 1'b0;
		#(ns) bus_reset_n = 1'b1;
		#80 soft_init_n = 1'b1;
	endtask : bus_reset
endmodule : bar_far

// ### bench/tb_top.sv
/*
 * Bench top: drives register port and core inputs, checks pins and
 * read data. Assumes bar_far stands for the rest of the bus.
 */
`timescale 1ns/100ps
module tb_top
	import bar_pkg::*;
;
	logic              ref_clk = 1'b0;
	logic              sys_rst = 1'b1;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic              reg_wr = 1'b0;
	logic              reg_rd = 1'b0;
	logic              core_internal_error = 1'b0;
	logic              txn_error = 1'b0;
	logic              txn_initiator = 1'b0;
	logic              bus_owner = 1'b0;
	logic              resp_agent = 1'b0;
	logic              temp_at_max = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic              irq, thermal_control_circuit, internal_error_n;
	logic              cache_invalidate, bist_start;
	logic              machine_check_error_n_out, machine_check_error_n_oe;
	logic              thermal_alert_n_out, thermal_alert_n_oe;
	logic [REQ_W-1:0]  request_cmd_n_out;
	logic [RS_W-1:0]   response_status_n_out;
	logic              request_cmd_n_oe, response_status_n_oe;
	logic              response_parity_n_out, response_parity_n_oe;
	logic [31:0]       seed = 32'h42;
	logic [31:0]       exp_q[$], msk_q[$];
	logic              rd_d = 1'b0;
	logic [4:0]        cmd;
	logic [7:0]        cfg;
	int                err_total = 0, tests_run = 0;
	int                inv_cnt = 0, bist_cnt = 0;
	localparam logic [8:0] MC_TAB [5] = '{9'h39, 9'h28, 9'h57, 9'h54, 9'h95};

	// Shared lines resolved from every party
	wire       mce_ln = u_far.mce_n &
		(machine_check_error_n_oe ? machine_check_error_n_out : 1'b1);
	wire       hot_ln = u_far.hot_n &
		(thermal_alert_n_oe ? thermal_alert_n_out : 1'b1);
	wire [4:0] req_ln = request_cmd_n_oe ? request_cmd_n_out :
		u_far.req_oe ? u_far.req_n : 5'h1f;
	wire [2:0] rs_ln  = response_status_n_oe ? response_status_n_out :
		u_far.rs_oe ? u_far.rs_n : 3'h7;
	wire       rsp_ln = response_parity_n_oe ? response_parity_n_out :
		u_far.rs_oe ? u_far.rsp_n : 1'b1;
	wire [4:0] all_oe = {request_cmd_n_oe, thermal_alert_n_oe,
		machine_check_error_n_oe, response_status_n_oe, response_parity_n_oe};

	bar_far u_far();

	bar_agent #(
		.RESET_MAX_CYC (50)
	) u_dut (
		.ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .irq, .core_internal_error, .txn_error, .txn_initiator,
		.bus_owner, .resp_agent, .temp_at_max, .thermal_control_circuit,
		.internal_error_n, .cache_invalidate, .bist_start,
		.machine_check_error_n_in (mce_ln), .machine_check_error_n_out,
		.machine_check_error_n_oe, .thermal_alert_n_in (hot_ln),
		.thermal_alert_n_out, .thermal_alert_n_oe,
		.bus_reset_n (u_far.bus_reset_n), .power_good_in (u_far.power_good_in),
		.soft_init_n (u_far.soft_init_n), .config_pins (u_far.config_pins),
		.address_strobe0_n (u_far.strobe_n), .request_cmd_n_in (req_ln),
		.request_cmd_n_out, .request_cmd_n_oe, .response_status_n_in (rs_ln),
		.response_status_n_out, .response_status_n_oe,
		.response_parity_n_in (rsp_ln), .response_parity_n_out,
		.response_parity_n_oe
	);

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	task automatic print_verdict();
		$display("Checks %0d, errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict

	task automatic cmp(input string nm, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : cmp

	task automatic cmp_rd(input logic [31:0] g);
		logic [31:0] e, m;
		e = exp_q.pop_front();
		m = msk_q.pop_front();
		cmp("reg read", e & m, g & m);
	endtask : cmp_rd

	task automatic bus(input logic w, r, input logic [ADDR_W-1:0] a,
		input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr    <= w;
		reg_rd    <= r;
		reg_addr  <= a;
		reg_wdata <= d;
	endtask : bus

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		bus(1'b0, 1'b1, a, '0);
	endtask : rd

	task automatic idle(input int n);
		repeat (n) bus(1'b0, 1'b0, '0, '0);
	endtask : idle

	task automatic tcc_is(input logic e);
		@(negedge ref_clk);
		cmp("tcc", 32'(e), 32'(thermal_control_circuit));
	endtask : tcc_is

	// Read data stands one cycle after the strobe; pulses are counted
	always @(posedge ref_clk) begin
		if (rd_d)
			cmp_rd(reg_rdata);
		rd_d <= reg_rd;
		if (cache_invalidate === 1'b1)
			inv_cnt++;
		if (bist_start === 1'b1)
			bist_cnt++;
	end

	initial begin
		forever #4 ref_clk = ~ref_clk;
	end

	initial begin
		#200000;
		err_total++;
		print_verdict();
	end

	initial begin
		repeat (12) @(posedge ref_clk);
		sys_rst <= 1'b0;
		idle(8);
		rd(OFS_CTRL, 32'h0, 32'h1f);
		rd(OFS_STATUS, 32'h4, 32'h3f);
		rd(OFS_IRQ_STATUS, 32'h20, 32'h7f);
		wr(OFS_CONFIG, 32'hff);
		wr(8'h24, 32'hff);
		rd(8'h24, 32'h0, '1);
		rd(OFS_CONFIG, 32'h3c, 32'hff);
		foreach (MC_TAB[i]) begin
			wr(OFS_CTRL, 32'(MC_TAB[i][8:4]));
			idle(1);
			core_internal_error <= MC_TAB[i][3];
			txn_error           <= MC_TAB[i][2];
			txn_initiator       <= MC_TAB[i][1];
			idle(1);
			core_internal_error <= 1'b0;
			txn_error           <= 1'b0;
			@(negedge ref_clk);
			cmp("mce drive", 32'(MC_TAB[i][0]), 32'(all_oe[2]));
			cmp("mce line", 32'(!MC_TAB[i][0]), 32'(mce_ln));
			idle(4);
			@(negedge ref_clk);
			cmp("mce end", 32'h0, 32'(all_oe[2]));
		end
		cmp("internal_error_n", 32'h0, 32'(internal_error_n));
		wr(OFS_IRQ_CLEAR, 32'h7f);
		rd(OFS_IRQ_STATUS, 32'h0, 32'h1);
		idle(1);
		u_far.pull_mce();
		idle(6);
		rd(OFS_IRQ_STATUS, 32'h1, 32'h1);
		wr(OFS_CTRL, 32'h10);
		temp_at_max <= 1'b1;
		idle(3);
		tcc_is(1'b1);
		cmp("hot line", 32'h0, 32'(hot_ln));
		idle(1);
		temp_at_max <= 1'b0;
		idle(3);
		tcc_is(1'b0);
		cmp("hot drive", 32'h0, 32'(thermal_alert_n_oe));
		idle(1);
		u_far.hot_n <= 1'b0;
		idle(8);
		tcc_is(1'b1);
		idle(20);
		tcc_is(1'b1);
		idle(1);
		u_far.hot_n <= 1'b1;
		idle(8);
		tcc_is(1'b0);
		wr(OFS_CTRL, 32'h0);
		u_far.hot_n <= 1'b0;
		idle(8);
		tcc_is(1'b0);
		idle(1);
		u_far.hot_n <= 1'b1;
		repeat (3) begin
			cmd = 5'(xs());
			idle(1);
			u_far.send_req(cmd);
			idle(3);
			rd(OFS_REQ_SEEN, 32'(cmd), 32'h1f);
			wr(OFS_REQ_DRIVE, 32'h100 | 32'(cmd));
			bus_owner <= 1'b1;
			idle(3);
			@(negedge ref_clk);
			cmp("req line", {27'h0, ~cmd}, {27'h0, req_ln});
			idle(1);
			bus_owner <= 1'b0;
			idle(2);
			@(negedge ref_clk);
			cmp("req drive", 32'h0, 32'(request_cmd_n_oe));
		end
		idle(1);
		resp_agent <= 1'b1;
		for (int s = 0; s < 8; s++) begin
			wr(OFS_RSP_DRIVE, 32'h100 | 32'(s));
			idle(3);
			@(negedge ref_clk);
			cmp("rsp line", {29'h0, ~3'(s)}, {29'h0, rs_ln});
			cmp("rsp parity", 32'(~^3'(s)), 32'(rsp_ln));
		end
		idle(1);
		resp_agent <= 1'b0;
		idle(2);
		@(negedge ref_clk);
		cmp("rsp drive", 32'h0, 32'(all_oe[1:0]));
		rd(OFS_IRQ_STATUS, 32'h0f, 32'h0f);
		wr(OFS_RSP_DRIVE, 32'h0);
		wr(OFS_IRQ_CLEAR, 32'h7f);
		wr(OFS_IRQ_ENABLE, 32'h10);
		idle(1);
		u_far.send_rsp(3'h3, 1'b1);
		idle(4);
		@(negedge ref_clk);
		cmp("irq", 32'h0, 32'(irq));
		u_far.send_rsp(3'h5, 1'b0);
		idle(4);
		@(negedge ref_clk);
		cmp("irq", 32'h1, 32'(irq));
		wr(OFS_IRQ_ENABLE, 32'h0);
		idle(3);
		@(negedge ref_clk);
		cmp("irq", 32'h0, 32'(irq));
		wr(OFS_IRQ_ENABLE, 32'h10);
		idle(3);
		@(negedge ref_clk);
		cmp("irq", 32'h1, 32'(irq));
		wr(OFS_IRQ_CLEAR, 32'h10);
		idle(3);
		@(negedge ref_clk);
		cmp("irq", 32'h0, 32'(irq));
		wr(OFS_REQ_DRIVE, 32'h101);
		bus_owner   <= 1'b1;
		temp_at_max <= 1'b1;
		idle(4);
		@(negedge ref_clk);
		cmp("drive before", 32'h18, 32'(all_oe));
		rd(OFS_STATUS, 32'h34, 32'h3f);
		idle(1);
		cfg = 8'(xs());
		fork
			u_far.bus_reset(200, cfg, 1'b0);
		join_none
		idle(5);
		@(negedge ref_clk);
		cmp("bus outputs", 32'h0, 32'(all_oe));
		idle(40);
		bus_owner   <= 1'b0;
		temp_at_max <= 1'b0;
		@(negedge ref_clk);
		cmp("invalidate", 32'h1, 32'(inv_cnt));
		cmp("self-test", 32'h1, 32'(bist_cnt));
		cmp("internal_error_n", 32'h1, 32'(internal_error_n));
		rd(OFS_CONFIG, 32'(cfg), 32'hff);
		rd(OFS_REQ_DRIVE, 32'h0, 32'h1ff);
		idle(1);
		u_far.bus_reset(800, cfg, 1'b1);
		idle(8);
		rd(OFS_IRQ_STATUS, 32'h40, 32'h40);
		idle(3);
		@(negedge ref_clk);
		cmp("invalidate", 32'h2, 32'(inv_cnt));
		cmp("self-test", 32'h1, 32'(bist_cnt));
		print_verdict();
	end
endmodule : tb_top
